//--- rtl/mci_pkg.sv
// Constants, types and commands of the motion-module command interpreter.
// Assumes one clock domain and an outside program store and EEPROM port.
package mci_pkg;
  // ====================================================================
  // Sizes and limits
  localparam int unsigned VAR_COUNT = 256;
  localparam logic [8:0] VAR_END = 9'h100;
  localparam logic [3:0] STACK_DEPTH = 4'h8;
  localparam logic [2:0] STARTUP_WAIT = 3'h4;
  localparam logic [9:0] PC_RESET = 10'h000;
  // ====================================================================
  // Command codes, banks and parameter numbers
  localparam logic [7:0] OP_SET_VAR = 8'h01;
  localparam logic [7:0] OP_GET_VAR = 8'h02;
  localparam logic [7:0] OP_ACC_TO_VAR = 8'h03;
  localparam logic [7:0] OP_SAVE_NV = 8'h04;
  localparam logic [7:0] OP_RESTORE_NV = 8'h05;
  localparam logic [7:0] OP_ACCUMULATOR_ARITH_CMD = 8'h06;
  localparam logic [7:0] OP_CALL = 8'h07;
  localparam logic [7:0] OP_RETURN = 8'h08;
  localparam logic [7:0] OP_JUMP = 8'h09;
  localparam logic [7:0] OP_STOP = 8'h0A;
  localparam logic [7:0] OP_RUN = 8'h0B;
  localparam logic [7:0] ACCUMULATOR_ARITH_CMD_ADD = 8'h00;
  localparam logic [7:0] ACCUMULATOR_ARITH_CMD_SUB = 8'h01;
  localparam logic [7:0] ACCUMULATOR_ARITH_CMD_MUL = 8'h02;
  localparam logic [7:0] BANK_GLOBAL = 8'h00;
  localparam logic [7:0] BANK_USER = 8'h02;
  localparam logic [7:0] GP_AUTOSTART = 8'h4D;
  localparam logic [7:0] GP_RESTORE = 8'h55;
  localparam logic [7:0] STAT_OK = 8'h00;
  localparam logic [7:0] STAT_BAD_CMD = 8'h01;
  localparam logic [7:0] STAT_BAD_BANK = 8'h02;
  // ====================================================================
  // Types
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] sel;
    logic [7:0] bank;
    logic [31:0] value;
  } mci_cmd_t;
  typedef struct packed {
    logic [7:0] status;
    logic [31:0] value;
  } mci_reply_t;
  typedef enum logic [2:0] {S_INIT, S_RESTORE, S_IDLE, S_FETCH, S_LOAD, S_DISP, S_NV} mci_state_t;
endpackage : mci_pkg

//--- rtl/mci_top.sv
// Command interpreter: user variables, accumulator, call stack, program run.
// Assumes a program store with one-cycle read latency and an EEPROM req/ack port.
`timescale 1ns/10ps
module mci_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cfg_autostart_pin,
  input wire logic cfg_restore_pin,
  input wire logic host_valid,
  input wire mci_pkg::mci_cmd_t host_cmd,
  output logic host_ready,
  output logic rep_valid,
  output mci_pkg::mci_reply_t rep,
  output logic [9:0] prog_addr,
  input wire mci_pkg::mci_cmd_t prog_data,
  output logic nv_req,
  output logic nv_we,
  output logic [7:0] nv_addr,
  output logic [31:0] nv_wdata,
  input wire logic nv_ack,
  input wire logic [31:0] nv_rdata,
  output logic running,
  output logic stack_err
);
  // ====================================================================
  // Functions
  function automatic logic [31:0] mci_accumulator_arith_cmd(input logic [7:0] sel, input logic [31:0] a,
                                           input logic [31:0] b);
    logic [63:0] prod;
    prod = a * b;
    case (sel)
      mci_pkg::ACCUMULATOR_ARITH_CMD_ADD: mci_accumulator_arith_cmd = a + b;
      mci_pkg::ACCUMULATOR_ARITH_CMD_SUB: mci_accumulator_arith_cmd = a - b;
      mci_pkg::ACCUMULATOR_ARITH_CMD_MUL: mci_accumulator_arith_cmd = prod[31:0];
      default: mci_accumulator_arith_cmd = a;
    endcase
  endfunction : mci_accumulator_arith_cmd

  // ====================================================================
  // State
  mci_pkg::mci_state_t state_q, state_d;
  mci_pkg::mci_cmd_t cmd_q;
  logic host_src_q, boot_q, autostart_q, restore_q;
  logic [2:0] as_sync_q, rv_sync_q;
  logic as_lvl_q, rv_lvl_q;
  logic [2:0] init_cnt_q;
  logic [8:0] rst_idx_q;
  logic [9:0] pc_q;
  logic [3:0] sp_q;
  logic [9:0] stack_q [0:7];
  logic [31:0] vars_q [0:mci_pkg::VAR_COUNT-1];
  logic [31:0] acc_q;

  // ====================================================================
  // Decode
  wire disp = state_q == mci_pkg::S_DISP;
  wire prog_disp = disp && !host_src_q;
  wire host_disp = disp && host_src_q;
  wire [7:0] vidx = cmd_q.sel;
  wire [31:0] var_rd = vars_q[vidx];
  wire user_bank = cmd_q.bank == mci_pkg::BANK_USER;
  wire op_set = cmd_q.op == mci_pkg::OP_SET_VAR;
  wire op_get = cmd_q.op == mci_pkg::OP_GET_VAR;
  wire op_atv = cmd_q.op == mci_pkg::OP_ACC_TO_VAR;
  wire op_save = cmd_q.op == mci_pkg::OP_SAVE_NV;
  wire op_rest = cmd_q.op == mci_pkg::OP_RESTORE_NV;
  wire op_accumulator_arith_cmd = cmd_q.op == mci_pkg::OP_ACCUMULATOR_ARITH_CMD;
  wire op_call = cmd_q.op == mci_pkg::OP_CALL;
  wire op_ret = cmd_q.op == mci_pkg::OP_RETURN;
  wire op_jump = cmd_q.op == mci_pkg::OP_JUMP;
  wire op_stop = cmd_q.op == mci_pkg::OP_STOP;
  wire op_run = cmd_q.op == mci_pkg::OP_RUN;
  wire var_op = op_set || op_get || op_atv || op_save || op_rest;
  wire gp_set = op_set && cmd_q.bank == mci_pkg::BANK_GLOBAL;
  wire gp_auto = gp_set && vidx == mci_pkg::GP_AUTOSTART;
  wire gp_rest = gp_set && vidx == mci_pkg::GP_RESTORE;
  wire bank_bad = var_op && !user_bank && !gp_auto && !gp_rest;
  // Host may touch variables and start or stop, never the stack or accumulator math
  wire host_bad = !(var_op || op_run || op_stop);
  wire call_ok = sp_q != mci_pkg::STACK_DEPTH;
  wire ret_ok = sp_q != 4'h0;
  wire [9:0] pc_inc = pc_q + 10'h001;
  wire [9:0] target = cmd_q.value[9:0];
  wire [9:0] ret_pc = stack_q[3'(sp_q - 4'h1)];
  wire [31:0] accumulator_arith_cmd_res = mci_accumulator_arith_cmd(vidx, acc_q, cmd_q.value);
  wire nv_start = disp && user_bank && (op_save || op_rest) && !(host_src_q && host_bad);
  wire nv_done = state_q == mci_pkg::S_NV && nv_ack;
  wire boot_done = state_q == mci_pkg::S_RESTORE && rst_idx_q == mci_pkg::VAR_END;
  wire init_done = state_q == mci_pkg::S_INIT && init_cnt_q == mci_pkg::STARTUP_WAIT;
  wire var_wr_cmd = disp && user_bank && (op_set || op_atv) && !(host_src_q && host_bad);
  wire var_we = var_wr_cmd || (nv_done && !nv_we);
  wire [7:0] var_wa = nv_done ? nv_addr : vidx;
  wire [31:0] var_wd = nv_done ? nv_rdata : (op_set ? cmd_q.value : acc_q);
  wire host_take = host_valid && host_ready;
  wire rep_fire = (host_disp && !nv_start) || (nv_done && host_src_q && !boot_q);
  wire [7:0] rep_stat = nv_done ? mci_pkg::STAT_OK :
                        host_bad ? mci_pkg::STAT_BAD_CMD :
                        bank_bad ? mci_pkg::STAT_BAD_BANK : mci_pkg::STAT_OK;
  wire [31:0] rep_val = nv_done ? nv_rdata : var_rd;

  // ====================================================================
  // Sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      mci_pkg::S_INIT: if (init_done) state_d = rv_lvl_q ? mci_pkg::S_RESTORE : mci_pkg::S_IDLE;
      mci_pkg::S_RESTORE: state_d = boot_done ? mci_pkg::S_IDLE : mci_pkg::S_NV;
      mci_pkg::S_IDLE: begin
        if (host_take) state_d = mci_pkg::S_DISP;
        else if (running) state_d = mci_pkg::S_FETCH;
      end
      mci_pkg::S_FETCH: state_d = mci_pkg::S_LOAD;
      mci_pkg::S_LOAD: state_d = mci_pkg::S_DISP;
      mci_pkg::S_DISP: state_d = nv_start ? mci_pkg::S_NV : mci_pkg::S_IDLE;
      mci_pkg::S_NV: if (nv_ack) state_d = boot_q ? mci_pkg::S_RESTORE : mci_pkg::S_IDLE;
      default: state_d = mci_pkg::S_INIT;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= mci_pkg::S_INIT;
      host_ready <= 1'b0;
    end else begin
      state_q <= state_d;
      host_ready <= state_d == mci_pkg::S_IDLE;
    end
  end

  // ====================================================================
  // Startup straps, three-stage synchronised, taken after they settle
  always_ff @(posedge mclk) begin
    if (rst) begin
      as_sync_q <= 3'h0;
      rv_sync_q <= 3'h0;
      as_lvl_q <= 1'b0;
      rv_lvl_q <= 1'b0;
      init_cnt_q <= 3'h0;
    end else begin
      as_sync_q <= {as_sync_q[1:0], cfg_autostart_pin};
      rv_sync_q <= {rv_sync_q[1:0], cfg_restore_pin};
      if (as_sync_q[1] == as_sync_q[2]) as_lvl_q <= as_sync_q[2];
      if (rv_sync_q[1] == rv_sync_q[2]) rv_lvl_q <= rv_sync_q[2];
      if (!init_done && state_q == mci_pkg::S_INIT) init_cnt_q <= init_cnt_q + 3'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      autostart_q <= 1'b0;
      restore_q <= 1'b0;
      boot_q <= 1'b1;
      rst_idx_q <= 9'h000;
    end else begin
      if (init_done) begin
        autostart_q <= as_lvl_q;
        restore_q <= rv_lvl_q;
        boot_q <= rv_lvl_q;
      end
      if (boot_done) boot_q <= 1'b0;
      if (state_q == mci_pkg::S_RESTORE && !boot_done) rst_idx_q <= rst_idx_q + 9'h001;
      if (disp && gp_auto) autostart_q <= cmd_q.value[0];
      if (disp && gp_rest) restore_q <= cmd_q.value[0];
    end
  end

  // ====================================================================
  // Command register and program flow
  always_ff @(posedge mclk) begin
    if (rst) begin
      cmd_q <= '0;
      host_src_q <= 1'b0;
      prog_addr <= mci_pkg::PC_RESET;
    end else if (state_q == mci_pkg::S_IDLE) begin
      if (host_take) begin
        cmd_q <= host_cmd;
        host_src_q <= 1'b1;
      end
      prog_addr <= pc_q;
    end else if (state_q == mci_pkg::S_LOAD) begin
      cmd_q <= prog_data;
      host_src_q <= 1'b0;
    end
  end

  // Host commands leave pc and stack alone except run, which reloads pc and clears sp
  always_ff @(posedge mclk) begin
    if (rst) begin
      pc_q <= mci_pkg::PC_RESET;
      sp_q <= 4'h0;
      running <= 1'b0;
      stack_err <= 1'b0;
    end else if ((init_done && !rv_lvl_q) || boot_done) begin
      pc_q <= mci_pkg::PC_RESET;
      running <= init_done ? as_lvl_q : autostart_q;
    end else if (host_disp && op_run) begin
      pc_q <= target;
      sp_q <= 4'h0;
      running <= 1'b1;
      stack_err <= 1'b0;
    end else if (host_disp && op_stop) begin
      running <= 1'b0;
    end else if (prog_disp) begin
      pc_q <= pc_inc;
      if (op_call && call_ok) begin
        pc_q <= target;
        sp_q <= sp_q + 4'h1;
      end else if (op_call || (op_ret && !ret_ok)) begin
        pc_q <= pc_q;
        running <= 1'b0;
        stack_err <= 1'b1;
      end else if (op_ret) begin
        pc_q <= ret_pc;
        sp_q <= sp_q - 4'h1;
      end else if (op_jump) begin
        pc_q <= target;
      end else if (op_stop || op_run) begin
        pc_q <= pc_q;
        running <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (prog_disp && op_call && call_ok) stack_q[sp_q[2:0]] <= pc_inc;
  end

  // ====================================================================
  // Variables and accumulator; reset clears all, restore then overwrites
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < mci_pkg::VAR_COUNT; i++) vars_q[i] <= 32'h0000_0000;
    end else if (var_we) begin
      vars_q[var_wa] <= var_wd;
    end
  end

  // Only the program owns the accumulator, so host reads cannot upset it
  always_ff @(posedge mclk) begin
    if (rst) acc_q <= 32'h0000_0000;
    else if (prog_disp && op_get && user_bank) acc_q <= var_rd;
    else if (prog_disp && op_accumulator_arith_cmd) acc_q <= accumulator_arith_cmd_res;
  end

  // ====================================================================
  // EEPROM port, request held until acknowledge
  always_ff @(posedge mclk) begin
    if (rst) begin
      nv_req <= 1'b0;
      nv_we <= 1'b0;
      nv_addr <= 8'h00;
      nv_wdata <= 32'h0000_0000;
    end else if (nv_done) begin
      nv_req <= 1'b0;
    end else if (state_q == mci_pkg::S_RESTORE && !boot_done) begin
      nv_req <= 1'b1;
      nv_we <= 1'b0;
      nv_addr <= rst_idx_q[7:0];
    end else if (nv_start) begin
      nv_req <= 1'b1;
      nv_we <= op_save;
      nv_addr <= vidx;
      nv_wdata <= var_rd;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rep_valid <= 1'b0;
      rep <= '0;
    end else begin
      rep_valid <= rep_fire;
      if (rep_fire) rep <= '{status: rep_stat, value: rep_val};
    end
  end

  // ====================================================================
  // Assertions
  sequence s_prog_call;
    prog_disp && op_call;
  endsequence
  sequence s_host_plain;
    host_disp && !op_run && !op_stop;
  endsequence

  property p_set_var;
    @(posedge mclk) disable iff (rst)
    disp && op_set && user_bank && !nv_done |=> vars_q[$past(vidx)] == $past(cmd_q.value);
  endproperty
  a_set_var: assert property (p_set_var) else $error("set variable lost");

  property p_get_var;
    @(posedge mclk) disable iff (rst)
    prog_disp && op_get && user_bank |=> acc_q == $past(var_rd);
  endproperty
  a_get_var: assert property (p_get_var) else $error("get variable wrong");

  property p_acc_to_var;
    @(posedge mclk) disable iff (rst)
    disp && op_atv && user_bank && !host_bad |=> vars_q[$past(vidx)] == $past(acc_q);
  endproperty
  a_acc_to_var: assert property (p_acc_to_var) else $error("acc store wrong");

  property p_save_nv;
    @(posedge mclk) disable iff (rst)
    nv_start && op_save |=> nv_req && nv_we && nv_wdata == $past(var_rd) ##0 nv_req[*1];
  endproperty
  a_save_nv: assert property (p_save_nv) else $error("save not issued");

  property p_restore_nv;
    @(posedge mclk) disable iff (rst)
    nv_done && !nv_we |=> vars_q[$past(nv_addr)] == $past(nv_rdata) && !nv_req;
  endproperty
  a_restore_nv: assert property (p_restore_nv) else $error("restore lost");

  property p_mul;
    @(posedge mclk) disable iff (rst)
    prog_disp && op_accumulator_arith_cmd && vidx == mci_pkg::ACCUMULATOR_ARITH_CMD_MUL |=>
      acc_q == 32'($past(acc_q) * $past(cmd_q.value));
  endproperty
  a_mul: assert property (p_mul) else $error("multiply wrong");

  property p_host_flow;
    @(posedge mclk) disable iff (rst)
    s_host_plain |=> $stable(pc_q) && $stable(sp_q) && $stable(acc_q);
  endproperty
  a_host_flow: assert property (p_host_flow) else $error("host disturbed flow");

  property p_call;
    @(posedge mclk) disable iff (rst)
    s_prog_call ##0 call_ok |=> pc_q == $past(target) && stack_q[$past(sp_q[2:0])] == $past(pc_inc);
  endproperty
  a_call: assert property (p_call) else $error("call wrong");

  property p_depth;
    @(posedge mclk) disable iff (rst)
    sp_q <= mci_pkg::STACK_DEPTH;
  endproperty
  a_depth: assert property (p_depth) else $error("stack too deep");

  property p_run;
    @(posedge mclk) disable iff (rst)
    host_disp && op_run |=> running && pc_q == $past(target) ##1 state_q == mci_pkg::S_FETCH;
  endproperty
  a_run: assert property (p_run) else $error("run not started");

  property p_autostart;
    @(posedge mclk) disable iff (rst)
    boot_done |=> running == $past(autostart_q) && pc_q == mci_pkg::PC_RESET;
  endproperty
  a_autostart: assert property (p_autostart) else $error("autostart wrong");

  property p_overflow;
    @(posedge mclk) disable iff (rst)
    s_prog_call ##0 !call_ok |=> !running && stack_err && $stable(sp_q);
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not caught");
endmodule : mci_top

//--- tb/mci_env_model.sv
// Far-side model: program store with one-cycle read, and user-variable EEPROM.
// Assumes the bench loads prog and ee before reset is released.
`timescale 1ns/10ps
module mci_env_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [9:0] prog_addr,
  output mci_pkg::mci_cmd_t prog_data,
  input wire logic nv_req,
  input wire logic nv_we,
  input wire logic [7:0] nv_addr,
  input wire logic [31:0] nv_wdata,
  output logic nv_ack,
  output logic [31:0] nv_rdata
);
  // ==========================================================
  // Storage
  mci_pkg::mci_cmd_t prog [1024];
  logic [31:0] ee [256];
  logic [1:0] wait_q;
  initial begin
    prog_data = '0;
    nv_ack = 1'b0;
    nv_rdata = 32'h0;
    wait_q = 2'h0;
  end
  // ==========================================================
  // Program store
  always @(posedge mclk) begin
    prog_data <= prog[prog_addr];
  end
  // ==========================================================
  // EEPROM; read data scrambles outside the ack cycle so stale values never match
  always @(posedge mclk) begin
    nv_ack <= 1'b0;
    nv_rdata <= ~nv_rdata;
    if (rst || nv_req !== 1'b1 || nv_ack) begin
      wait_q <= 2'($urandom_range(3, 0));
    end else if (wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
    end else begin
      nv_ack <= 1'b1;
      if (nv_we) begin
        ee[nv_addr] <= nv_wdata;
      end else begin
        nv_rdata <= ee[nv_addr];
      end
    end
  end
endmodule : mci_env_model

//--- tb/motion_module_command_interpreter_test.sv
// Self-checking bench: host commands, stored programs, startup straps.
// Assumes mci_top and mci_env_model; host side is driven by tasks here.
`timescale 1ns/10ps
module motion_module_command_interpreter_test;
  // ==========================================================
  // Signals and instances
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cfg_autostart_pin = 1'b0;
  logic cfg_restore_pin = 1'b1;
  logic host_valid = 1'b0;
  mci_pkg::mci_cmd_t host_cmd = '0;
  mci_pkg::mci_cmd_t prog_data;
  mci_pkg::mci_reply_t rep;
  mci_pkg::mci_reply_t r;
  logic host_ready, rep_valid, nv_req, nv_we, nv_ack, running, stack_err;
  logic [9:0] prog_addr;
  logic [7:0] nv_addr;
  logic [31:0] nv_wdata, nv_rdata;
  logic [31:0] var_m [256];
  int num_errors = 0;
  int compares = 0;
  always #4 mclk = ~mclk;
  mci_top DUT (.mclk(mclk), .rst(rst), .cfg_autostart_pin(cfg_autostart_pin),
    .cfg_restore_pin(cfg_restore_pin), .host_valid(host_valid), .host_cmd(host_cmd),
    .host_ready(host_ready), .rep_valid(rep_valid), .rep(rep), .prog_addr(prog_addr),
    .prog_data(prog_data), .nv_req(nv_req), .nv_we(nv_we), .nv_addr(nv_addr),
    .nv_wdata(nv_wdata), .nv_ack(nv_ack), .nv_rdata(nv_rdata), .running(running),
    .stack_err(stack_err));
  mci_env_model env (.mclk(mclk), .rst(rst), .prog_addr(prog_addr), .prog_data(prog_data),
    .nv_req(nv_req), .nv_we(nv_we), .nv_addr(nv_addr), .nv_wdata(nv_wdata),
    .nv_ack(nv_ack), .nv_rdata(nv_rdata));
  // ==========================================================
  // Tasks
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task results;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  task xfer(input logic [7:0] op, input logic [7:0] sel, input logic [7:0] bank,
            input logic [31:0] val);
    int n;
    logic rdy;
    n = 0;
    rdy = 1'b0;
    @(posedge mclk);
    host_valid <= 1'b1;
    host_cmd <= {op, sel, bank, val};
    // Ready is read mid-cycle, so the loop ends on the very edge that takes the command
    while (rdy !== 1'b1 && n < 5000) begin
      @(negedge mclk);
      rdy = host_ready;
      @(posedge mclk);
      n++;
    end
    host_valid <= 1'b0;
    @(negedge mclk);
    while (rep_valid !== 1'b1 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    check(32'(n < 5000), 32'h1, "reply");
    r = rep;
  endtask : xfer
  task set_var(input logic [7:0] i, input logic [31:0] v);
    xfer(mci_pkg::OP_SET_VAR, i, mci_pkg::BANK_USER, v);
    // The reply carries the variable as it stood before the write
    check(r.value, var_m[i], "set echo");
    var_m[i] = v;
  endtask : set_var
  task get_var(input logic [7:0] i);
    xfer(mci_pkg::OP_GET_VAR, i, mci_pkg::BANK_USER, 32'h0);
    check({24'h0, r.status}, 32'h0, "get status");
    check(r.value, var_m[i], "get value");
  endtask : get_var
  task run_at(input logic [9:0] a, input logic wait_end);
    int n;
    n = 0;
    xfer(mci_pkg::OP_RUN, 8'h00, 8'h00, {22'h0, a});
    repeat (2) @(posedge mclk);
    while (wait_end && running !== 1'b0 && n < 5000) begin
      @(posedge mclk);
      n++;
    end
  endtask : run_at
  task do_reset(input logic auto_s, input logic rest_s);
    @(posedge mclk);
    cfg_autostart_pin <= auto_s;
    cfg_restore_pin <= rest_s;
    rst <= 1'b1;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
  endtask : do_reset
  function automatic mci_pkg::mci_cmd_t ins(logic [7:0] op, logic [7:0] sel,
                                            logic [31:0] val);
    return {op, sel, mci_pkg::BANK_USER, val};
  endfunction : ins
  // ==========================================================
  // Watchdog, sized well above the longest expected run
  initial begin
    repeat (60000) @(posedge mclk);
    num_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    results();
  end
  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] i;
    logic [31:0] v;
    logic [7:0] bad_ops [4];
    int n;
    void'($urandom(32'h2C3E));
    bad_ops = '{mci_pkg::OP_ACCUMULATOR_ARITH_CMD, mci_pkg::OP_CALL, mci_pkg::OP_RETURN, mci_pkg::OP_JUMP};
    for (int k = 0; k < 1024; k++) env.prog[k] = ins(mci_pkg::OP_STOP, 8'h00, 32'h0);
    for (int k = 0; k < 256; k++) begin
      v = $urandom;
      env.ee[k] = v;
      var_m[k] = v;
    end
    // Jump table first so routine entries never move
    env.prog[0] = ins(mci_pkg::OP_JUMP, 8'h00, 32'h3);
    env.prog[1] = ins(mci_pkg::OP_JUMP, 8'h00, 32'hA);
    env.prog[2] = ins(mci_pkg::OP_JUMP, 8'h00, 32'h14);
    env.prog[3] = ins(mci_pkg::OP_SET_VAR, 8'h0A, 32'h4D2);
    env.prog[4] = ins(mci_pkg::OP_GET_VAR, 8'h0A, 32'h0);
    env.prog[5] = ins(mci_pkg::OP_ACCUMULATOR_ARITH_CMD, mci_pkg::ACCUMULATOR_ARITH_CMD_MUL, 32'h2);
    env.prog[6] = ins(mci_pkg::OP_ACC_TO_VAR, 8'h0B, 32'h0);
    env.prog[10] = ins(mci_pkg::OP_CALL, 8'h00, 32'h28);
    env.prog[11] = ins(mci_pkg::OP_SET_VAR, 8'h0C, 32'h7);
    env.prog[20] = ins(mci_pkg::OP_CALL, 8'h00, 32'h3C);
    env.prog[21] = ins(mci_pkg::OP_SET_VAR, 8'h0F, 32'h3);
    for (int k = 0; k < 8; k++) begin
      env.prog[40 + 2 * k] = ins(mci_pkg::OP_CALL, 8'h00, 32'(42 + 2 * k));
      env.prog[41 + 2 * k] = ins(mci_pkg::OP_RETURN, 8'h00, 32'h0);
      env.prog[60 + 2 * k] = ins(mci_pkg::OP_CALL, 8'h00, 32'(62 + 2 * k));
      env.prog[61 + 2 * k] = ins(mci_pkg::OP_RETURN, 8'h00, 32'h0);
    end
    env.prog[54] = ins(mci_pkg::OP_SET_VAR, 8'h0D, 32'h5);
    env.prog[76] = ins(mci_pkg::OP_SET_VAR, 8'h0E, 32'h9);
    env.prog[80] = ins(mci_pkg::OP_GET_VAR, 8'h14, 32'h0);
    env.prog[81] = ins(mci_pkg::OP_ACC_TO_VAR, 8'h15, 32'h0);
    env.prog[82] = ins(mci_pkg::OP_JUMP, 8'h00, 32'h50);
    do_reset(1'b0, 1'b1);
    for (int k = 0; k < 4; k++) get_var(8'($urandom_range(255, 100)));
    for (int k = 0; k < 4; k++) begin
      i = 8'($urandom_range(255, 100));
      set_var(i, $urandom);
      get_var(i);
    end
    foreach (bad_ops[k]) begin
      xfer(bad_ops[k], 8'h00, mci_pkg::BANK_USER, 32'h0);
      check({24'h0, r.status}, 32'h1, "program-only op");
    end
    xfer(mci_pkg::OP_GET_VAR, 8'h05, mci_pkg::BANK_GLOBAL, 32'h0);
    check({24'h0, r.status}, 32'h2, "wrong bank");
    xfer(mci_pkg::OP_SET_VAR, mci_pkg::GP_AUTOSTART, mci_pkg::BANK_GLOBAL, 32'h0);
    check({24'h0, r.status}, 32'h0, "autostart flag");
    xfer(mci_pkg::OP_SET_VAR, mci_pkg::GP_RESTORE, mci_pkg::BANK_GLOBAL, 32'h1);
    check({24'h0, r.status}, 32'h0, "restore flag");
    v = $urandom;
    set_var(8'hC8, v);
    xfer(mci_pkg::OP_SAVE_NV, 8'hC8, mci_pkg::BANK_USER, 32'h0);
    check(env.ee[200], v, "saved copy");
    set_var(8'hC8, ~v);
    xfer(mci_pkg::OP_RESTORE_NV, 8'hC8, mci_pkg::BANK_USER, 32'h0);
    var_m[200] = v;
    get_var(8'hC8);
    run_at(10'h000, 1'b1);
    var_m[10] = 32'h4D2;
    var_m[11] = var_m[10] * 2;
    get_var(8'h0A);
    get_var(8'h0B);
    run_at(10'h001, 1'b1);
    var_m[13] = 32'h5;
    var_m[12] = 32'h7;
    get_var(8'h0D);
    get_var(8'h0C);
    check({31'h0, stack_err}, 32'h0, "eight levels");
    run_at(10'h002, 1'b1);
    check({31'h0, stack_err}, 32'h1, "ninth call");
    get_var(8'h0E);
    get_var(8'h0F);
    run_at(10'h050, 1'b0);
    check({31'h0, stack_err}, 32'h0, "run clears error");
    v = $urandom;
    set_var(8'h14, v);
    repeat (40) @(posedge mclk);
    check({31'h0, running}, 32'h1, "program undisturbed");
    var_m[21] = v;
    get_var(8'h15);
    xfer(mci_pkg::OP_STOP, 8'h00, 8'h00, 32'h0);
    repeat (2) @(posedge mclk);
    check({31'h0, running}, 32'h0, "stopped");
    do_reset(1'b1, 1'b0);
    n = 0;
    while (running !== 1'b1 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    check({31'h0, running}, 32'h1, "autostart");
    while (running !== 1'b0 && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    for (int k = 0; k < 256; k++) var_m[k] = 32'h0;
    var_m[10] = 32'h4D2;
    var_m[11] = var_m[10] * 2;
    get_var(8'h0B);
    get_var(8'h64);
    results();
  end
endmodule : motion_module_command_interpreter_test
